// ==== hdl/adcscr_map.svh ====
// constants for the serial configuration register block
// assumes inclusion by the top module only
`ifndef ADCSCR_MAP_SVH
`define ADCSCR_MAP_SVH
// ----------------------------------------------------------------
// field positions of conversion_config
// ----------------------------------------------------------------
`define ADCSCR_WRITE_BIT 11
`define ADCSCR_SEQ_HI_BIT 10
`define ADCSCR_CHAN_HI_BIT 7
`define ADCSCR_CHAN_LO_BIT 6
`define ADCSCR_PM_HI_BIT 5
`define ADCSCR_PM_LO_BIT 4
`define ADCSCR_SEQ_LO_BIT 3
`define ADCSCR_RANGE_BIT 1
`define ADCSCR_CODING_BIT 0
// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define ADCSCR_CFG_RESET 12'h030
`define ADCSCR_CFG_EDGES 5'h0C
`define ADCSCR_MUX_EDGE 5'h0E
`define ADCSCR_FRAME_EDGES 5'h10
`define ADCSCR_WAKE_NS 1000
`define ADCSCR_CLK_NS 5
`define ADCSCR_WAKE_CYC ((`ADCSCR_WAKE_NS + `ADCSCR_CLK_NS - 1) / `ADCSCR_CLK_NS)
`endif

// ==== hdl/adcscr_pkg.sv ====
// types for the serial configuration register block
// assumes the map header sits beside it
package adcscr_pkg;
	typedef enum logic [1:0] {
		ADCSCR_PM_INVALID = 2'h0,
		ADCSCR_PM_AUTO = 2'h1,
		ADCSCR_PM_SHUTDOWN = 2'h2,
		ADCSCR_PM_NORMAL = 2'h3
	} adcscr_power_type;
	typedef enum logic [1:0] {
		ADCSCR_SEQ_OFF0 = 2'h0,
		ADCSCR_SEQ_OFF1 = 2'h1,
		ADCSCR_SEQ_KEEP = 2'h2,
		ADCSCR_SEQ_RUN = 2'h3
	} adcscr_seq_type;
endpackage

// ==== hdl/adcscr_fifo.sv ====
// parameterised valid/ready fifo for conversion results
// assumes a single clock and synchronous active-low reset
`timescale 1ns/10ps
module adcscr_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;
	assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign out_data_o = mem_reg[rd_ptr_reg];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule // adcscr_fifo

// ==== hdl/adcscr_top.sv ====
// serial configuration register and frame logic of a four-channel converter
// assumes sclk, din and cs_n come from pins in another domain; results
// arrive from the converter core through a valid/ready stream
//
// How it works
// - one 12-bit write-only configuration register, never read back.
// - din bits are captured on falling serial clock edges.
// - new configuration applies to next conversion (power mode here at once, from the twelfth edge); current result shifts out.
// - only first twelve falling-edge bits load; later bits ignored.
// - first bit is bit 11, then descending to bit 0.
// - bit 11 high loads other eleven bits; low keeps register.
// - bits 10 and 3 form the two-bit sequencer code.
// - channel field latched at conversion end; next or final channel.
// - two channel bits precede the twelve result bits on dout.
// - mux switches to next channel on the fourteenth falling edge.
// - bits 5 and 4 choose the power mode.
// - bit 1 zero gives double span, one gives reference span.
// - bit 0 zero gives twos complement, one straight binary.
// - power 11 normal, 10 shutdown, 01 auto shutdown, 00 illegal.
// - sequencer code 11 steps channels zero up to address field.
// - frame is two zeros, two channel bits, twelve result bits msb first.
`timescale 1ns/10ps
`include "adcscr_map.svh"
module adcscr_top
	import adcscr_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic sclk_i,
	input wire logic din_i,
	input wire logic cs_n_i,
	output logic dout_o,
	output logic dout_oe_o,
	input wire logic result_valid_i,
	output logic result_ready_o,
	input wire logic [11:0] result_data_i,
	output logic [1:0] mux_channel_o,
	output logic [1:0] power_mode_o,
	output logic powered_o,
	output logic range_ref_o,
	output logic coding_binary_o,
	output logic convert_start_o,
	output logic illegal_power_o
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] sclk_meta_reg;
	logic [1:0] din_meta_reg;
	logic [2:0] cs_meta_reg;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sclk_meta_reg <= 3'h7;
			din_meta_reg <= 2'h0;
			cs_meta_reg <= 3'h7;
		end else begin
			sclk_meta_reg <= {sclk_meta_reg[1:0], sclk_i};
			din_meta_reg <= {din_meta_reg[0], din_i};
			cs_meta_reg <= {cs_meta_reg[1:0], cs_n_i};
		end
	end
	// edges are judged only between stages two and three
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic cs_low;
	logic din_s;
	assign sclk_fall = sclk_meta_reg[2] && !sclk_meta_reg[1];
	assign cs_fall = cs_meta_reg[2] && !cs_meta_reg[1];
	assign cs_rise = !cs_meta_reg[2] && cs_meta_reg[1];
	assign cs_low = !cs_meta_reg[1];
	assign din_s = din_meta_reg[1];
	// ----------------------------------------------------------------
	// frame counter and input shifter
	// ----------------------------------------------------------------
	logic [4:0] edge_cnt_reg;
	logic [11:0] shift_in_reg;
	logic frame_fall;
	assign frame_fall = cs_low && !cs_fall && sclk_fall;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			edge_cnt_reg <= 5'h00;
		end else if (cs_fall || cs_rise) begin
			edge_cnt_reg <= 5'h00;
		end else if (frame_fall && edge_cnt_reg != `ADCSCR_FRAME_EDGES) begin
			edge_cnt_reg <= edge_cnt_reg + 5'h01;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			shift_in_reg <= 12'h000;
		end else if (frame_fall && edge_cnt_reg < `ADCSCR_CFG_EDGES) begin
			shift_in_reg <= {shift_in_reg[10:0], din_s};
		end
	end
	// word complete on the twelfth edge, taken once
	logic load_pulse;
	assign load_pulse = frame_fall && edge_cnt_reg == (`ADCSCR_CFG_EDGES - 5'h01);
	logic [11:0] word_in;
	assign word_in = {shift_in_reg[10:0], din_s};
	// ----------------------------------------------------------------
	// configuration register
	// ----------------------------------------------------------------
	// write-only: no path leads it back to dout
	logic [11:0] cfg_reg;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cfg_reg <= `ADCSCR_CFG_RESET;
		end else if (load_pulse && word_in[`ADCSCR_WRITE_BIT]) begin
			cfg_reg <= word_in;
		end
	end
	adcscr_seq_type seq_code;
	adcscr_power_type pm_code;
	// sequencer code from 10 and 3
	assign seq_code = adcscr_seq_type'({cfg_reg[`ADCSCR_SEQ_HI_BIT],
		cfg_reg[`ADCSCR_SEQ_LO_BIT]});
	assign pm_code = adcscr_power_type'({cfg_reg[`ADCSCR_PM_HI_BIT],
		cfg_reg[`ADCSCR_PM_LO_BIT]});
	// ----------------------------------------------------------------
	// conversion settings: channel taken on the fourteenth edge, the rest at the end of each frame
	// ----------------------------------------------------------------
	logic frame_end;
	assign frame_end = frame_fall && edge_cnt_reg == (`ADCSCR_FRAME_EDGES - 5'h01);
	logic [1:0] next_chan_reg;
	logic [1:0] seq_pos_reg;
	logic seq_active_reg;
	logic [1:0] chan_next;
	logic cfg_fresh_reg;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cfg_fresh_reg <= 1'b0;
		end else if (load_pulse) begin
			cfg_fresh_reg <= word_in[`ADCSCR_WRITE_BIT];
		end else if (cs_fall) begin
			cfg_fresh_reg <= 1'b0;
		end
	end
	// address field chooses next or final channel
	always_comb begin
		chan_next = next_chan_reg;
		if (cfg_fresh_reg && seq_code == ADCSCR_SEQ_RUN) begin
			chan_next = 2'h0;
		end else if (seq_active_reg && (!cfg_fresh_reg || seq_code[1])) begin
			chan_next = (seq_pos_reg == cfg_reg[7:6]) ? 2'h0 : seq_pos_reg + 2'h1;
		end else if (cfg_fresh_reg) begin
			chan_next = cfg_reg[`ADCSCR_CHAN_HI_BIT:`ADCSCR_CHAN_LO_BIT];
		end
	end
	// fresh write with code 0x leaves sequencing
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			seq_active_reg <= 1'b0;
			seq_pos_reg <= 2'h0;
		end else if (frame_end) begin
			if (cfg_fresh_reg) begin
				seq_active_reg <= seq_code == ADCSCR_SEQ_RUN ||
					(seq_active_reg && seq_code == ADCSCR_SEQ_KEEP);
			end
			seq_pos_reg <= chan_next;
		end
	end
	// mux moves on the fourteenth edge
	logic mux_edge;
	assign mux_edge = frame_fall && edge_cnt_reg == (`ADCSCR_MUX_EDGE - 5'h01);
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			next_chan_reg <= 2'h0;
			mux_channel_o <= 2'h0;
		end else if (mux_edge) begin
			next_chan_reg <= chan_next;
			mux_channel_o <= chan_next;
		end
	end
	// settings apply from the next conversion
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			range_ref_o <= 1'b0;
			coding_binary_o <= 1'b0;
		end else if (frame_end) begin
			range_ref_o <= cfg_reg[`ADCSCR_RANGE_BIT];
			coding_binary_o <= cfg_reg[`ADCSCR_CODING_BIT];
		end
	end
	// ----------------------------------------------------------------
	// power control
	// ----------------------------------------------------------------
	// auto mode needs the wake time after select falls before a valid result
	logic [8:0] wake_cnt_reg;
	logic awake_reg;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			power_mode_o <= 2'h3;
			illegal_power_o <= 1'b0;
		end else begin
			power_mode_o <= pm_code;
			illegal_power_o <= pm_code == ADCSCR_PM_INVALID;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			awake_reg <= 1'b1;
			wake_cnt_reg <= 9'h000;
		end else begin
			unique case (pm_code)
				ADCSCR_PM_NORMAL: begin
					awake_reg <= 1'b1;
				end
				ADCSCR_PM_SHUTDOWN, ADCSCR_PM_INVALID: begin
					awake_reg <= 1'b0;
				end
				ADCSCR_PM_AUTO: begin
					if (frame_end) begin
						awake_reg <= 1'b0;
					end else if (cs_fall) begin
						wake_cnt_reg <= 9'(`ADCSCR_WAKE_CYC);
					end else if (wake_cnt_reg != 9'h000) begin
						wake_cnt_reg <= wake_cnt_reg - 9'h001;
						if (wake_cnt_reg == 9'h001) begin
							awake_reg <= 1'b1;
						end
					end
				end
			endcase
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			powered_o <= 1'b1;
		end else begin
			powered_o <= awake_reg;
		end
	end
	// ----------------------------------------------------------------
	// result fifo and output shifter
	// ----------------------------------------------------------------
	logic fifo_out_valid;
	logic [13:0] fifo_out_data;
	logic fifo_in_ready;
	logic fifo_pop;
	adcscr_fifo #(
		.WIDTH(14),
		.DEPTH(8)
	) u_fifo (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(result_valid_i && result_ready_o),
		.in_ready_o(fifo_in_ready),
		.in_data_i({mux_channel_o, result_data_i}),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_out_data)
	);
	// core stalls when the host stops reading frames
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			result_ready_o <= 1'b0;
		end else begin
			result_ready_o <= fifo_in_ready && !(result_valid_i && result_ready_o);
		end
	end
	// one result per frame; an empty fifo sends zeros
	assign fifo_pop = cs_fall && fifo_out_valid;
	logic [15:0] shift_out_reg;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			shift_out_reg <= 16'h0000;
		end else if (cs_fall) begin
			shift_out_reg <= fifo_out_valid ? {2'h0, fifo_out_data} : 16'h0000;
		end else if (frame_fall) begin
			shift_out_reg <= {shift_out_reg[14:0], 1'b0};
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			dout_o <= 1'b0;
			dout_oe_o <= 1'b0;
			convert_start_o <= 1'b0;
		end else begin
			dout_o <= cs_fall ? 1'b0 : (frame_fall ? shift_out_reg[14] : dout_o);
			dout_oe_o <= cs_low;
			convert_start_o <= cs_fall && awake_reg;
		end
	end
endmodule // adcscr_top

// ==== sim/adcscr_checker.sv ====
// port checks for the serial configuration register block
// assumes it is bound to adcscr_top, single core clock domain
`timescale 1ns/10ps
module adcscr_checker
	import adcscr_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic cs_n_i,
	input wire logic dout_oe_o,
	input wire logic [1:0] mux_channel_o,
	input wire logic [1:0] power_mode_o,
	input wire logic range_ref_o,
	input wire logic coding_binary_o,
	input wire logic convert_start_o,
	input wire logic illegal_power_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_oe_on; $fell(cs_n_i) ##1 !cs_n_i[*4] |-> dout_oe_o; endproperty
	a_oe_on: assert property (p_oe_on) else $error("oe late");
	property p_oe_off; cs_n_i[*5] |-> !dout_oe_o; endproperty
	a_oe_off: assert property (p_oe_off) else $error("oe stuck");
	property p_ill; illegal_power_o == (power_mode_o == ADCSCR_PM_INVALID);
	endproperty
	a_ill: assert property (p_ill) else $error("illegal flag");
	property p_st_one; convert_start_o |=> !convert_start_o; endproperty
	a_st_one: assert property (p_st_one) else $error("start long");
	property p_st_cs; convert_start_o |-> !$past(cs_n_i, 2); endproperty
	a_st_cs: assert property (p_st_cs) else $error("start no cs");
	property p_rng; $changed(range_ref_o) |-> !cs_n_i; endproperty
	a_rng: assert property (p_rng) else $error("range off frame");
	property p_cod; $changed(coding_binary_o) |-> !cs_n_i; endproperty
	a_cod: assert property (p_cod) else $error("coding off frame");
	property p_mux; $changed(mux_channel_o) |-> !cs_n_i; endproperty
	a_mux: assert property (p_mux) else $error("mux off frame");
	property p_pm; $changed(power_mode_o) |-> !cs_n_i; endproperty
	a_pm: assert property (p_pm) else $error("power off frame");
	c_start: cover property (convert_start_o);
	c_ill: cover property (illegal_power_o);
	c_mux: cover property ($changed(mux_channel_o));
endmodule // adcscr_checker
bind adcscr_top adcscr_checker u_chk (.core_clk_i(core_clk_i),
	.rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .dout_oe_o(dout_oe_o),
	.mux_channel_o(mux_channel_o), .power_mode_o(power_mode_o),
	.range_ref_o(range_ref_o), .coding_binary_o(coding_binary_o),
	.convert_start_o(convert_start_o), .illegal_power_o(illegal_power_o));

// ==== sim/adcscr_host_model.sv ====
// host serial controller model for the select-framed link
// assumes sclk idles high and stands still between frames
`timescale 1ns/10ps
module adcscr_host_model (
	output logic sclk_o,
	output logic din_o,
	output logic cs_n_o,
	input wire logic dout_i
);
	int half = 32;
	initial begin
		sclk_o = 1'b1;
		din_o = 1'b0;
		cs_n_o = 1'b1;
	end
	task automatic xfer(input logic [15:0] w, input int edges,
		output logic [15:0] rx);
		rx = 16'h0000;
		cs_n_o <= 1'b0;
		din_o <= w[15];
		#(half);
		for (int i = 0; i < edges; i++) begin
			rx[15-i] = dout_i;
			sclk_o <= 1'b0;
			#(half);
			sclk_o <= 1'b1;
			if (i < 15) din_o <= w[14-i];
			#(half);
		end
		cs_n_o <= 1'b1;
		// no pull on din: released line must not look held
		din_o <= ~din_o;
		#(half * 4);
	endtask
endmodule // adcscr_host_model

// ==== sim/tb.sv ====
// self-checking bench for the serial configuration register block
// assumes the host model drives the link, the bench the result stream
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
	num_errors++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb
	import adcscr_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sclk, din, cs_n, dout, oe, rr, pwr, rng, cod, start, ill;
	logic rv = 1'b0;
	logic [11:0] rd = 12'h000;
	logic [1:0] mux, pm;
	logic [15:0] rx;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	always #2.5 clk = ~clk;
	adcscr_top dut (.core_clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk),
		.din_i(din), .cs_n_i(cs_n), .dout_o(dout), .dout_oe_o(oe),
		.result_valid_i(rv), .result_ready_o(rr), .result_data_i(rd),
		.mux_channel_o(mux), .power_mode_o(pm), .powered_o(pwr),
		.range_ref_o(rng), .coding_binary_o(cod),
		.convert_start_o(start), .illegal_power_o(ill));
	adcscr_host_model u_host (.sclk_o(sclk), .din_o(din), .cs_n_o(cs_n),
		.dout_i(dout));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// a hang costs one mismatch; frames take about 260 cycles each
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	task automatic frame(input logic [11:0] w);
		u_host.xfer({w, 4'hF}, 16, rx);
		repeat (20) @(posedge clk);
	endtask
	task automatic push(input logic [11:0] d);
		@(posedge clk);
		rv <= 1'b1;
		rd <= d;
		do @(posedge clk); while (rr !== 1'b1);
		rv <= 1'b0;
		#1;
		`CHK("ready gap", 1'b0, rr)
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_write();
		`CHK("pm rst", ADCSCR_PM_NORMAL, pm)
		`CHK("rng rst", 1'b0, rng)
		frame(12'hAB3);
		`CHK("mux", 2'h2, mux)
		`CHK("pm", 2'h3, pm)
		`CHK("rng", 1'b1, rng)
		`CHK("cod", 1'b1, cod)
		frame(12'h07C);
		`CHK("gate rng", 1'b1, rng)
		`CHK("gate mux", 2'h2, mux)
		$display("t_write done");
	endtask
	task automatic t_power();
		u_host.xfer(16'h8000, 8, rx);
		repeat (20) @(posedge clk);
		`CHK("abort pm", 2'h3, pm)
		frame(12'h801);
		`CHK("ill", 1'b1, ill)
		frame(12'h8A1);
		`CHK("down", 1'b0, pwr)
		frame(12'h8B0);
		repeat (250) @(posedge clk);
		`CHK("wake", 1'b1, pwr)
		frame(12'h890);
		`CHK("auto", 1'b0, pwr)
		$display("t_power done");
	endtask
	task automatic t_dout();
		push(12'hA5C);
		u_host.half = 48;
		frame(12'h830);
		u_host.half = 32;
		`CHK("frame", 16'h2A5C, rx)
		`CHK("mux0", 2'h0, mux)
		$display("t_dout done");
	endtask
	task automatic t_seq();
		logic [11:0] w[5] = '{12'hC78, 12'hC70, 12'h000, 12'h830, 12'h000};
		logic [1:0] e[5] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
		for (int i = 0; i < 5; i++) begin
			frame(w[i]);
			`CHK("seq mux", e[i], mux)
		end
		$display("t_seq done");
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_write();
		t_power();
		t_dout();
		t_seq();
		finish_test();
	end
endmodule // tb
